/* File: src/lsr_pkg.sv */
// Constants for the lamp shutdown and status register block
package lsr_pkg;

    // ====================
    // Clock and timing
    localparam int unsigned CLK_KHZ          = 125000;
    localparam int unsigned LAMP_OUT_MS      = 2000;
    localparam int unsigned LAMP_OUT_CYCLES  = LAMP_OUT_MS * CLK_KHZ;
    localparam int unsigned TIMER_W          = 28;

    // ====================
    // Command byte layout
    localparam int unsigned CMD_HI_BIT       = 7;
    localparam int unsigned CMD_SUB_BIT      = 6;
    localparam logic [1:0]  SEL_BRIGHT       = 2'h1;
    localparam logic [1:0]  SEL_STATUS       = 2'h2;
    localparam logic [1:0]  SEL_PART         = 2'h3;
    localparam logic [1:0]  SEL_REV          = 2'h0;
    localparam int unsigned WIDE_STATUS_BIT  = 1;
    localparam int unsigned ID_SEL_BIT       = 0;

    // ====================
    // Field positions
    localparam int unsigned MODE_W           = 3;
    localparam int unsigned BRIGHT_W         = 5;
    localparam int unsigned OFF_LOW_POS      = 0;
    localparam int unsigned OFF_HIGH_POS     = 1;
    localparam int unsigned FORCE_OFF_POS    = 2;

    // ====================
    // Reset values
    localparam logic [2:0]  MODE_RST         = 3'h1;
    localparam logic        LAMP_PRESENT_RST = 1'h1;
    localparam logic        NO_OC_RST        = 1'h1;
    localparam logic [7:0]  RDATA_RST        = 8'h00;

    // ====================
    // Identity values (arbitrary)
    localparam logic [7:0]  MAKER_CODE_DEF   = 8'h5a;
    localparam logic [7:0]  PART_CODE_DEF    = 8'h3c;
    localparam logic [7:0]  REV_CODE_DEF     = 8'h01;

endpackage : lsr_pkg

/* File: src/lsr_fault_if.sv */
// Link between the mode/status control and the lamp-out timer
`timescale 1ns/1ps
`default_nettype none

interface lsr_fault_if;
    logic arm;
    logic expired;

    modport ctrl  (output arm, input expired);
    modport timer (input arm, output expired);
endinterface : lsr_fault_if

`default_nettype wire

/* File: src/lsr_lamp_timer.sv */
// Lamp-out timeout: counts how long the lamp current stays under threshold
`timescale 1ns/1ps
`default_nettype none

module lsr_lamp_timer #(
    parameter int unsigned LIMIT = lsr_pkg::LAMP_OUT_CYCLES
) (
    input  wire logic     clock,
    input  wire logic     resetn,
    input  wire logic     lamp_current_low,
    lsr_fault_if.timer    flt
);

    localparam logic [lsr_pkg::TIMER_W-1:0] LAST = lsr_pkg::TIMER_W'(LIMIT - 1);

    // ====================
    // Input synchroniser
    logic low_meta_q;
    logic low_sync_q;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            low_meta_q <= 1'b0;
            low_sync_q <= 1'b0;
        end
        else
        begin
            low_meta_q <= lamp_current_low;
            low_sync_q <= low_meta_q;
        end
    end

    // ====================
    // Timeout counter
    logic [lsr_pkg::TIMER_W-1:0] cnt_q;

    // Any pulse of lamp current restarts the full timeout
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q <= '0;
        end
        else if (!flt.arm || !low_sync_q)
        begin
            cnt_q <= '0;
        end
        else if (cnt_q != LAST)
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign flt.expired = flt.arm && low_sync_q && (cnt_q == LAST);

endmodule : lsr_lamp_timer

`default_nettype wire

/* File: src/lsr_regs.sv */
// Shutdown-mode decode, fault status flags and identity registers
// Function
// - Top mode bit forces off; else pin low uses bit 0, pin high bit 1.
// - Lamp-out flag reads 0 after a lamp-out detection, 1 otherwise.
// - Lamp-out flag stays 0 after the fault goes away until a shutdown or a suspend-pin toggle.
// - A mode-bit shutdown or any suspend-pin toggle, even one that leaves the lamp lit, returns the lamp-out flag to 1.
// - Overcurrent flag reads 0 if overcurrent seen last dimming period, else 1.
// - Status flag bits are read-only; writes to the status register change only the mode field.
// - Lamp-out flag at bit 7, overcurrent flag at bit 6 (bits 1 and 0 in the wide read), both reset to 1.
// - Three read-only identity registers return fixed maker, part and revision codes.
// - Writes to identity registers are ignored.
// - Lamp-out flag clears after two seconds with lamp current below threshold.
// - While lamp-out flag is 0 the lamp stays forced off.
// - Overcurrent flag updates once per dimming period and holds through the next.
// - Shutdown-mode bits reset to 001.
`timescale 1ns/1ps
`default_nettype none

module lsr_regs #(
    parameter int unsigned          LAMP_OUT_CYCLES = lsr_pkg::LAMP_OUT_CYCLES,
    parameter logic [7:0]           MAKER_CODE      = lsr_pkg::MAKER_CODE_DEF,   // arbitrary value
    parameter logic [7:0]           PART_CODE       = lsr_pkg::PART_CODE_DEF,    // arbitrary value
    parameter logic [7:0]           REVISION_CODE   = lsr_pkg::REV_CODE_DEF      // arbitrary value
) (
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic               suspend_pin,
    input  wire logic               lamp_current_low,
    input  wire logic               overcurrent,
    input  wire logic               period_end,
    input  wire logic [4:0]         bright_level,
    input  wire logic [7:0]         reg_cmd,
    input  wire logic               reg_wr,
    input  wire logic [7:0]         reg_wdata,
    output logic [7:0]              reg_rdata,
    output logic [2:0]              shutdown_mode,
    output logic                    lamp_off
);

    // ====================
    // Command decode
    typedef enum logic [2:0] {
        LSR_SEL_NONE   = 3'h0,
        LSR_SEL_BRIGHT = 3'h1,
        LSR_SEL_STATUS = 3'h2,
        LSR_SEL_PART   = 3'h3,
        LSR_SEL_REV    = 3'h4,
        LSR_SEL_WIDE   = 3'h5,
        LSR_SEL_MAKER  = 3'h6
    } lsr_sel_t;

    // Command bytes alias freely; only the listed bits matter
    function automatic lsr_sel_t lsr_decode(input logic [7:0] cmd);
        lsr_sel_t sel;
        sel = LSR_SEL_NONE;
        if (!cmd[lsr_pkg::CMD_HI_BIT])
        begin
            if (cmd[1:0] == lsr_pkg::SEL_BRIGHT)
                sel = LSR_SEL_BRIGHT;
            else if (cmd[1:0] == lsr_pkg::SEL_STATUS)
                sel = LSR_SEL_STATUS;
            else if (cmd[1:0] == lsr_pkg::SEL_PART)
                sel = LSR_SEL_PART;
            else
                sel = LSR_SEL_REV;
        end
        else if (!cmd[lsr_pkg::CMD_SUB_BIT])
        begin
            if (!cmd[lsr_pkg::WIDE_STATUS_BIT])
                sel = LSR_SEL_WIDE;
        end
        else if (cmd[lsr_pkg::ID_SEL_BIT])
        begin
            sel = LSR_SEL_PART;
        end
        else
        begin
            sel = LSR_SEL_MAKER;
        end
        return sel;
    endfunction : lsr_decode

    lsr_sel_t sel;
    assign sel = lsr_decode(reg_cmd);

    // ====================
    // Pin synchronisers
    logic sus_meta_q;
    logic sus_sync_q;
    logic sus_last_q;
    logic oc_meta_q;
    logic oc_sync_q;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sus_meta_q <= 1'b0;
            sus_sync_q <= 1'b0;
            sus_last_q <= 1'b0;
            oc_meta_q  <= 1'b0;
            oc_sync_q  <= 1'b0;
        end
        else
        begin
            sus_meta_q <= suspend_pin;
            sus_sync_q <= sus_meta_q;
            sus_last_q <= sus_sync_q;
            oc_meta_q  <= overcurrent;
            oc_sync_q  <= oc_meta_q;
        end
    end

    logic sus_toggle;
    assign sus_toggle = sus_sync_q ^ sus_last_q;

    // ====================
    // Shutdown-mode register
    logic [2:0] mode_q;
    logic       mode_wr;

    // Every alias of the status command writes the mode field
    assign mode_wr = reg_wr && (sel == LSR_SEL_STATUS);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= lsr_pkg::MODE_RST;
        end
        else if (mode_wr)
        begin
            // Only the mode field is writable; status bits in the byte are dropped
            mode_q <= reg_wdata[lsr_pkg::MODE_W-1:0];
        end
    end

    assign shutdown_mode = mode_q;

    // ====================
    // Mode decode
    logic mode_off;

    always_comb
    begin
        if (mode_q[lsr_pkg::FORCE_OFF_POS])
            mode_off = 1'b1;
        else if (sus_sync_q)
            mode_off = mode_q[lsr_pkg::OFF_HIGH_POS];
        else
            mode_off = mode_q[lsr_pkg::OFF_LOW_POS];
    end

    // ====================
    // Lamp-out flag
    logic         lamp_present_q;
    logic         lamp_set;
    logic         lamp_clear;
    lsr_fault_if  flt ();

    // Timer only runs while the lamp is meant to be lit
    assign flt.arm  = !mode_off && lamp_present_q;
    assign lamp_off = mode_off || !lamp_present_q;

    // Any pin toggle counts, even one that leaves the lamp running
    assign lamp_set   = mode_off || sus_toggle;
    assign lamp_clear = flt.expired;

    lsr_lamp_timer #(
        .LIMIT            (LAMP_OUT_CYCLES)
    ) u_timer (
        .clock            (clock),
        .resetn           (resetn),
        .lamp_current_low (lamp_current_low),
        .flt              (flt.timer)
    );

    // A shutdown wins over a same-cycle detection
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            lamp_present_q <= lsr_pkg::LAMP_PRESENT_RST;
        end
        else if (lamp_set)
        begin
            lamp_present_q <= 1'b1;
        end
        else if (lamp_clear)
        begin
            lamp_present_q <= 1'b0;
        end
    end

    // ====================
    // Overcurrent flag
    logic oc_seen_q;
    logic no_oc_q;
    logic oc_now;

    // An overcurrent in the boundary cycle still counts for the ending period
    assign oc_now = oc_seen_q || oc_sync_q;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            oc_seen_q <= 1'b0;
        end
        else if (period_end)
        begin
            oc_seen_q <= 1'b0;
        end
        else if (oc_sync_q)
        begin
            oc_seen_q <= 1'b1;
        end
    end

    // Sample at the period boundary and hold for the whole next period
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            no_oc_q <= lsr_pkg::NO_OC_RST;
        end
        else if (period_end)
        begin
            no_oc_q <= !oc_now;
        end
    end

    // ====================
    // Read data
    logic [1:0] status_bits;
    assign status_bits = {lamp_present_q, no_oc_q};

    // Writes reach only the mode field; status flags and identity bytes have no write path
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= lsr_pkg::RDATA_RST;
        end
        else
        begin
            case (sel)
                LSR_SEL_BRIGHT: reg_rdata <= {3'h0, bright_level};
                LSR_SEL_STATUS: reg_rdata <= {status_bits, 3'h7, mode_q};
                LSR_SEL_PART:   reg_rdata <= PART_CODE;
                LSR_SEL_REV:    reg_rdata <= REVISION_CODE;
                LSR_SEL_WIDE:   reg_rdata <= {bright_level, 1'b1, status_bits};
                LSR_SEL_MAKER:  reg_rdata <= MAKER_CODE;
                default:        reg_rdata <= lsr_pkg::RDATA_RST;
            endcase
        end
    end

endmodule : lsr_regs

`default_nettype wire

/* File: verification/lsr_regs_assertions.sv */
// Port-level assertions for the shutdown and status registers
`timescale 1ns/1ps
`default_nettype none

module lsr_regs_assertions #(
    parameter logic [7:0] MAKER_CODE    = lsr_pkg::MAKER_CODE_DEF,
    parameter logic [7:0] PART_CODE     = lsr_pkg::PART_CODE_DEF,
    parameter logic [7:0] REVISION_CODE = lsr_pkg::REV_CODE_DEF
) (
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       suspend_pin,
    input wire logic       period_end,
    input wire logic [7:0] reg_cmd,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] shutdown_mode,
    input wire logic       lamp_off
);
    logic pin_s1_q;
    logic pin_s2_q;
    logic dec_off;
    logic st;

    // Mirror of the pin synchroniser, so decode is judged on the same level
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= suspend_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign dec_off = shutdown_mode[2] | (pin_s2_q ? shutdown_mode[1] : shutdown_mode[0]);
    assign st = !reg_cmd[7] && (reg_cmd[1:0] == 2'h2);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_off_read;
        dec_off && st ##1 st;
    endsequence
    // No boundary in the first cycle, so the overcurrent flag of the next two reads agrees
    sequence s_period_quiet;
        (st && !period_end) ##1 st;
    endsequence
    sequence s_out_read;
        st ##1 !reg_rdata[7];
    endsequence

    chk_force_off: assert property (shutdown_mode[2] |-> lamp_off)
        else $error("lamp not off with force bit set");
    chk_decode_off: assert property (dec_off |-> lamp_off)
        else $error("lamp runs although decode shuts it down");
    chk_mode_write: assert property (reg_wr && st |=> shutdown_mode == $past(reg_wdata[2:0]))
        else $error("mode write not taken");
    chk_ro_write: assert property (reg_wr && !st |=> $stable(shutdown_mode))
        else $error("write to read-only place changed mode");
    chk_id_codes: assert property (reg_cmd[7:6] == 2'h3 |=>
        reg_rdata == ($past(reg_cmd[0]) ? PART_CODE : MAKER_CODE))
        else $error("wrong maker or part code");
    chk_rev_code: assert property (!reg_cmd[7] && reg_cmd[1:0] == 2'h0 |=> reg_rdata == REVISION_CODE)
        else $error("wrong revision code");
    chk_status_layout: assert property (st |=> reg_rdata[5:0] == {3'h7, $past(shutdown_mode)})
        else $error("status byte layout wrong");
    chk_flag_set: assert property (s_off_read |=> reg_rdata[7])
        else $error("shutdown did not set lamp flag");
    chk_oc_hold: assert property (s_period_quiet |=> $stable(reg_rdata[6]))
        else $error("overcurrent flag moved inside a period");
    chk_lamp_out_off: assert property (s_out_read |-> $past(lamp_off))
        else $error("lamp not held off after lamp-out");
endmodule : lsr_regs_assertions

bind lsr_regs lsr_regs_assertions #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE),
    .REVISION_CODE(REVISION_CODE)) chk_u (.clock(clock), .resetn(resetn), .suspend_pin(suspend_pin),
    .period_end(period_end), .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .shutdown_mode(shutdown_mode), .lamp_off(lamp_off));

`default_nettype wire

/* File: verification/lsr_host_model.sv */
// Host side model: register commands and the suspend pin
`timescale 1ns/1ps
`default_nettype none

module lsr_host_model (
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_cmd,
    output var  logic       reg_wr,
    output var  logic [7:0] reg_wdata,
    output var  logic       suspend_pin
);
    initial
    begin
        reg_cmd = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        suspend_pin = 1'b0;
    end

    task automatic write(input logic [7:0] cmd, input logic [7:0] data);
        @(negedge clock);
        reg_cmd = cmd;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        // Stale data must not look valid after the strobe
        reg_wdata = ~data;
    endtask : write

    task automatic read(input logic [7:0] cmd, output logic [7:0] data);
        @(negedge clock);
        reg_cmd = cmd;
        @(negedge clock);
        data = reg_rdata;
    endtask : read

    task automatic set_pin(input logic v);
        @(negedge clock);
        suspend_pin = v;
    endtask : set_pin
endmodule : lsr_host_model

`default_nettype wire

/* File: verification/lamp_shutdown_status_regs_bench.sv */
// Self-checking bench for the lamp shutdown and status registers
`timescale 1ns/1ps
`default_nettype none

module lamp_shutdown_status_regs_bench;
    localparam int unsigned LIMIT = 20;
    localparam logic [7:0] RD_CMD [8] = '{8'h03, 8'h04, 8'hfe, 8'hff, 8'h80, 8'h01, 8'h82, 8'h7b};
    localparam logic [7:0] RD_EXP [8] = '{lsr_pkg::PART_CODE_DEF, lsr_pkg::REV_CODE_DEF,
        lsr_pkg::MAKER_CODE_DEF, lsr_pkg::PART_CODE_DEF, 8'haf, 8'h15, 8'h00, lsr_pkg::PART_CODE_DEF};
    logic       clock;
    logic       resetn;
    logic       lamp_current_low;
    logic       overcurrent;
    logic       period_end;
    logic [4:0] bright_level;
    logic [7:0] reg_cmd;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic       suspend_pin;
    logic [7:0] reg_rdata;
    logic [2:0] shutdown_mode;
    logic       lamp_off;
    logic [7:0] rd;
    int         error_cnt = 0;
    int         checked = 0;

    lsr_regs #(.LAMP_OUT_CYCLES(LIMIT)) dut_u (.clock(clock), .resetn(resetn), .suspend_pin(suspend_pin),
        .lamp_current_low(lamp_current_low), .overcurrent(overcurrent), .period_end(period_end),
        .bright_level(bright_level), .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .shutdown_mode(shutdown_mode), .lamp_off(lamp_off));
    lsr_host_model host_u (.clock(clock), .reg_rdata(reg_rdata), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .suspend_pin(suspend_pin));

    // ====================
    // Compare and closing
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp8

    task automatic cmp1(input string what, input logic exp, input logic got);
        cmp8(what, {7'h0, exp}, {7'h0, got});
    endtask : cmp1

    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // ====================
    // Scenarios
    task automatic pulse_oc();
        overcurrent = 1'b1;
        repeat (2) @(negedge clock);
        overcurrent = 1'b0;
        repeat (3) @(negedge clock);
    endtask : pulse_oc

    task automatic end_period();
        period_end = 1'b1;
        @(negedge clock);
        period_end = 1'b0;
    endtask : end_period

    task automatic t_reset();
        host_u.read(8'h02, rd);
        cmp8("status", 8'hf9, rd);
        cmp8("mode", 8'h01, {5'h0, shutdown_mode});
        cmp1("lamp_off", 1'b1, lamp_off);
    endtask : t_reset

    task automatic t_modes();
        for (int i = 0; i < 16; i++)
        begin
            host_u.write(8'h02, {5'h0, i[2:0]});
            host_u.set_pin(i[3]);
            repeat (3) @(negedge clock);
            cmp1("lamp_off", i[2] | (i[3] ? i[1] : i[0]), lamp_off);
        end
    endtask : t_modes

    task automatic t_lamp_out();
        host_u.write(8'h02, 8'h00);
        host_u.set_pin(1'b0);
        lamp_current_low = 1'b1;
        repeat (LIMIT + 10) @(negedge clock);
        host_u.read(8'h02, rd);
        cmp8("status", 8'h78, rd);
        cmp1("lamp_off", 1'b1, lamp_off);
        lamp_current_low = 1'b0;
        repeat (LIMIT + 10) @(negedge clock);
        // A write that does not shut down must not revive the flag
        host_u.write(8'h02, 8'h00);
        host_u.read(8'h02, rd);
        cmp8("status", 8'h78, rd);
        host_u.write(8'h02, 8'h04);
        host_u.read(8'h02, rd);
        cmp8("status", 8'hfc, rd);
        host_u.write(8'h02, 8'h00);
        lamp_current_low = 1'b1;
        repeat (LIMIT + 10) @(negedge clock);
        host_u.read(8'h02, rd);
        cmp8("status", 8'h78, rd);
        lamp_current_low = 1'b0;
        host_u.set_pin(1'b1);
        repeat (3) @(negedge clock);
        host_u.read(8'h02, rd);
        cmp8("status", 8'hf8, rd);
        cmp1("lamp_off", 1'b0, lamp_off);
    endtask : t_lamp_out

    task automatic t_overcurrent();
        pulse_oc();
        end_period();
        host_u.read(8'h02, rd);
        cmp8("status", 8'hb8, rd);
        repeat (5) @(negedge clock);
        host_u.read(8'h02, rd);
        cmp8("status", 8'hb8, rd);
        end_period();
        host_u.read(8'h02, rd);
        cmp8("status", 8'hf8, rd);
        // An overcurrent inside a period stays hidden until that period ends
        pulse_oc();
        host_u.read(8'h02, rd);
        cmp8("status", 8'hf8, rd);
        end_period();
        host_u.read(8'h02, rd);
        cmp8("status", 8'hb8, rd);
        end_period();
        host_u.read(8'h02, rd);
        cmp8("status", 8'hf8, rd);
    endtask : t_overcurrent

    task automatic t_readonly();
        host_u.write(8'h02, 8'h3d);
        host_u.read(8'h02, rd);
        cmp8("status", 8'hfd, rd);
        for (int i = 0; i < 8; i++)
        begin
            host_u.write(RD_CMD[i], 8'h00);
            cmp8("mode", 8'h05, {5'h0, shutdown_mode});
            host_u.read(RD_CMD[i], rd);
            cmp8("read", RD_EXP[i], rd);
        end
    endtask : t_readonly

    // ====================
    // Clock, reset, sequence and watchdog
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial
    begin
        resetn = 1'b0;
        lamp_current_low = 1'b0;
        overcurrent = 1'b0;
        period_end = 1'b0;
        bright_level = 5'h15;
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        t_reset();
        t_modes();
        t_lamp_out();
        t_overcurrent();
        t_readonly();
        end_of_test();
    end

    initial
    begin
        #100000;
        error_cnt++;
        end_of_test();
    end
endmodule : lamp_shutdown_status_regs_bench

`default_nettype wire
